/* shared/can_timing_pkg.sv */
// Constants, register map and carrier types for the CAN bit timing and power mode block
package can_timing_pkg;

	// =====================================================================
	// Register byte offsets
	localparam logic [11:0] bit_timing_reg_a_off = 12'h000;
	localparam logic [11:0] bit_timing_reg_b_off = 12'h004;
	localparam logic [11:0] control_reg_a_off = 12'h008;
	localparam logic [11:0] status_reg_off = 12'h00c;

	// =====================================================================
	// Field positions: bit_timing_reg_a
	localparam int prescale_lsb = 0;
	localparam int prescale_w = 6;
	localparam int jump_width_lsb = 6;
	localparam int jump_width_w = 2;
	// Field positions: bit_timing_reg_b
	localparam int seg1_lsb = 0;
	localparam int seg1_w = 4;
	localparam int seg2_lsb = 4;
	localparam int seg2_w = 3;
	localparam int three_samp_bit = 7;
	// Field positions: control_reg_a
	localparam int sleep_req_pos = 0;
	localparam int wakeup_en_pos = 1;
	localparam int stop_in_wait_pos = 2;
	localparam int listen_only_pos = 3;
	localparam int wakeup_irq_en_pos = 4;
	localparam int module_enable_pos = 5;
	// Field positions: status register
	localparam int sleep_ack_pos = 0;
	localparam int power_down_pos = 1;
	localparam int disabled_pos = 2;
	localparam int wakeup_irq_pos = 3;
	localparam int sample_pos = 4;

	// =====================================================================
	// Reset values
	localparam logic [7:0] btr_a_rst = 8'h00;
	localparam logic [7:0] btr_b_rst = 8'h23;
	localparam logic [5:0] ctl_rst = 6'h00;

	// =====================================================================
	// Timing
	localparam int sync_seg_tq = 1;
	localparam int sleep_sync_cycles = 3;
	localparam logic [1:0] sleep_sync_last = 2'(sleep_sync_cycles - 1);
	localparam int idle_recessive_bits = 11;
	localparam logic [3:0] idle_last = 4'(idle_recessive_bits - 1);

	// =====================================================================
	// Types
	typedef enum logic [2:0] {
		st_normal = 3'b000,
		st_sleep_sync = 3'b001,
		st_sleep_wait = 3'b010,
		st_sleep = 3'b011,
		st_power_down = 3'b100,
		st_disabled = 3'b101
	} pwr_state_type;

	typedef enum logic [1:0] {
		seg_sync = 2'b00,
		seg_one = 2'b01,
		seg_two = 2'b10
	} seg_type;

	typedef enum logic [1:0] {
		cpu_run = 2'b00,
		cpu_wait = 2'b01,
		cpu_stop = 2'b10
	} cpu_mode_type;

	typedef struct packed {
		logic [5:0] prescale;
		logic [1:0] jump_width_field;
		logic three_samp;
		logic [2:0] seg2_len_field;
		logic [3:0] seg1_len_field;
	} timing_type;

	typedef struct packed {
		logic module_enable_bit;
		logic wakeup_irq_enable_bit;
		logic listen_only;
		logic stop_in_wait_bit;
		logic wakeup_enable_bit;
		logic sleep_request_bit;
	} control_type;

endpackage : can_timing_pkg

/* src/can_bit_timing_and_power_modes.sv */
// CAN bit timing generator with listen-only and power mode control behind an APB slave
// =====================================================================
// Behaviour
// - Quantum clock is the protocol clock divided by a programmable prescaler.
// - Sync segment is always exactly one quantum; edges expected there.
// - Segment one is programmable from 4 to 16 quanta.
// - Segment two is programmable from 2 to 8 quanta.
// - Transmit data is driven onto the bus at the transmit point.
// - Bus sampled at sample point; with three samples it marks the third.
// - Jump width programmable from 1 to 4 quanta.
// - Each timing field holds length minus one; jump width field at most 3.
// - Behaviour does not depend on system operating mode; here stop mode, or wait mode with stop-in-wait, forces power-down.
// - Listen-only receives frames, drives only recessive, never starts transmission.
// - Listen-only dominant bits are looped back internally, bus stays recessive.
// - Module enable low stops all controller clocks.
// - Sleep stops all clocks except register access clocks.
// - Power-down stops all clocks.
// - Stop mode forces power-down; run mode offers only sleep.
// - Wait mode with stop-in-wait powers down; leaving restarts into normal.
// - Wake-up interrupt only when sleeping, wake-up enabled and its enable set.
// - Sleep entered after a sync delay once bus activity permits.
// - Pending transmit buffers are emptied before sleep is entered.
// - A reception in progress finishes; sleep at next bus idle.
// - With no activity, sleep is entered right after the sync delay.
// - Sleep acknowledge set with request while sleeping; software handshakes on it.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps

module can_bit_timing_and_power_modes (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	// System and protocol side
	input wire can_timing_pkg::cpu_mode_type i_cpu_mode,
	input wire logic [2:0] i_tx_buffer_empty_flag,
	input wire logic i_rx_busy,
	input wire logic i_tx_bit,
	input wire logic i_mac_dominant,
	// Bus pins
	input wire logic i_can_rx,
	output logic o_can_tx,
	// Protocol engine controls
	output logic o_tq_tick,
	output logic o_sample_strobe,
	output logic o_tx_point,
	output logic o_rx_bit,
	output logic o_tx_start_allowed,
	output logic o_engine_clk_en,
	output logic o_reg_clk_en,
	output logic [2:0] o_jump_width_tq,
	output logic o_wakeup_irq
);
	import can_timing_pkg::*;

	// =====================================================================
	// Registers
	timing_type timing_reg, timing_next;
	control_type ctl_reg, ctl_next;
	logic enable_locked_reg, enable_locked_next;
	pwr_state_type pwr_reg, pwr_next;
	logic [1:0] sync_cnt_reg, sync_cnt_next;
	logic [3:0] idle_cnt_reg, idle_cnt_next;
	logic [5:0] pre_cnt_reg, pre_cnt_next;
	seg_type seg_reg, seg_next;
	logic [3:0] seg_cnt_reg, seg_cnt_next;
	logic [2:0] samp_hist_reg, samp_hist_next;
	logic rx_bit_reg, rx_bit_next;
	logic tx_reg, tx_next;
	logic [31:0] rdata_reg, rdata_next;

	logic wr_en, rd_en, tq, sample_pt, tx_pt, running, bus_rx, sleep_ack;
	logic [3:0] seg1_last, seg2_last;

	// Length minus one to last count index, shared by both segments
	function automatic logic [3:0] seg_last(input logic [3:0] field);
		seg_last = field;
	endfunction : seg_last

	function automatic logic majority(input logic [2:0] v);
		majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction : majority

	// =====================================================================
	// APB decode; zero wait states
	assign wr_en = i_psel & i_penable & i_pwrite;
	assign rd_en = i_psel & ~i_penable & ~i_pwrite;
	assign o_pready = 1'b1;
	assign o_pslverr = 1'b0;
	assign o_prdata = rdata_reg;

	// Timing fields: 4 bits covers 1..16, 3 bits 1..8, 2 bits 1..4 quanta
	assign seg1_last = seg_last(timing_reg.seg1_len_field);
	assign seg2_last = seg_last({1'b0, timing_reg.seg2_len_field});
	assign o_jump_width_tq = {1'b0, timing_reg.jump_width_field} + 3'h1;

	assign sleep_ack = (pwr_reg == st_sleep);

	always_comb begin
		timing_next = timing_reg;
		ctl_next = ctl_reg;
		enable_locked_next = enable_locked_reg;
		rdata_next = rdata_reg;
		// Timing is frozen while the protocol engine is live, so bits never stretch mid-frame
		if (wr_en && i_paddr == bit_timing_reg_a_off && !running) begin
			timing_next.prescale = i_pwdata[prescale_lsb +: prescale_w];
			timing_next.jump_width_field = i_pwdata[jump_width_lsb +: jump_width_w];
		end
		if (wr_en && i_paddr == bit_timing_reg_b_off && !running) begin
			timing_next.seg1_len_field = i_pwdata[seg1_lsb +: seg1_w];
			timing_next.seg2_len_field = i_pwdata[seg2_lsb +: seg2_w];
			timing_next.three_samp = i_pwdata[three_samp_bit];
		end
		if (wr_en && i_paddr == control_reg_a_off) begin
			ctl_next.wakeup_enable_bit = i_pwdata[wakeup_en_pos];
			ctl_next.stop_in_wait_bit = i_pwdata[stop_in_wait_pos];
			ctl_next.listen_only = i_pwdata[listen_only_pos];
			ctl_next.wakeup_irq_enable_bit = i_pwdata[wakeup_irq_en_pos];
			// Request may only be dropped in normal mode or once sleep is acknowledged
			if (i_pwdata[sleep_req_pos] || sleep_ack || pwr_reg == st_normal)
				ctl_next.sleep_request_bit = i_pwdata[sleep_req_pos];
			// Enable is write-once to guard against accidental disable
			if (!enable_locked_reg) begin
				ctl_next.module_enable_bit = i_pwdata[module_enable_pos];
				enable_locked_next = 1'b1;
			end
		end
		// Bus activity wake-up clears the request
		if (pwr_reg == st_sleep && ctl_reg.wakeup_enable_bit && !i_can_rx)
			ctl_next.sleep_request_bit = 1'b0;
		if (rd_en) begin
			rdata_next = 32'h0000_0000;
			unique case (i_paddr)
				bit_timing_reg_a_off: rdata_next[7:0] = {timing_reg.jump_width_field, timing_reg.prescale};
				bit_timing_reg_b_off: rdata_next[7:0] = {timing_reg.three_samp, timing_reg.seg2_len_field,
					timing_reg.seg1_len_field};
				control_reg_a_off: rdata_next[5:0] = ctl_reg;
				status_reg_off: begin
					rdata_next[sleep_ack_pos] = sleep_ack;
					rdata_next[power_down_pos] = (pwr_reg == st_power_down);
					rdata_next[disabled_pos] = (pwr_reg == st_disabled);
					rdata_next[wakeup_irq_pos] = o_wakeup_irq;
					rdata_next[sample_pos] = rx_bit_reg;
				end
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			timing_reg <= timing_type'({btr_a_rst[5:0], btr_a_rst[7:6], btr_b_rst});
			ctl_reg <= control_type'(ctl_rst);
			enable_locked_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			timing_reg <= timing_next;
			ctl_reg <= ctl_next;
			enable_locked_reg <= enable_locked_next;
			rdata_reg <= rdata_next;
		end
	end

	// =====================================================================
	// Power mode arbitration; stop mode, or wait mode with stop-in-wait, forces power-down
	always_comb begin
		pwr_next = pwr_reg;
		sync_cnt_next = sync_cnt_reg;
		if (!ctl_reg.module_enable_bit) begin
			pwr_next = st_disabled;
		end else if (i_cpu_mode == cpu_stop ||
			(i_cpu_mode == cpu_wait && ctl_reg.stop_in_wait_bit)) begin
			pwr_next = st_power_down;
		end else begin
			unique case (pwr_reg)
				st_normal: begin
					sync_cnt_next = 2'h0;
					if (ctl_reg.sleep_request_bit)
						pwr_next = st_sleep_sync;
				end
				st_sleep_sync: begin
					sync_cnt_next = sync_cnt_reg + 2'h1;
					if (sync_cnt_reg == sleep_sync_last)
						pwr_next = st_sleep_wait;
				end
				st_sleep_wait: begin
					// Transmit drained, no reception busy and bus idle must all hold in the same cycle
					if (&i_tx_buffer_empty_flag && !i_rx_busy && idle_cnt_reg == idle_last)
						pwr_next = st_sleep;
				end
				st_sleep: begin
					if (!ctl_reg.sleep_request_bit)
						pwr_next = st_normal;
				end
				// Leaving power-down or disable restarts the engine in normal mode
				st_power_down: pwr_next = st_normal;
				st_disabled: pwr_next = st_normal;
				default: pwr_next = st_normal;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pwr_reg <= st_disabled;
			sync_cnt_reg <= 2'h0;
		end else begin
			pwr_reg <= pwr_next;
			sync_cnt_reg <= sync_cnt_next;
		end
	end

	// Clock gating requests to the clock tree
	assign running = (pwr_reg == st_normal) || (pwr_reg == st_sleep_sync) || (pwr_reg == st_sleep_wait);
	assign o_engine_clk_en = running;
	assign o_reg_clk_en = (pwr_reg != st_power_down) && (pwr_reg != st_disabled);
	assign o_wakeup_irq = sleep_ack && ctl_reg.sleep_request_bit && ctl_reg.wakeup_enable_bit &&
		ctl_reg.wakeup_irq_enable_bit && !i_can_rx;

	// =====================================================================
	// Bit timing
	assign tq = running && (pre_cnt_reg == timing_reg.prescale);
	assign tx_pt = tq && (seg_reg == seg_sync);
	assign sample_pt = tq && (seg_reg == seg_one) && (seg_cnt_reg == seg1_last);
	assign o_tq_tick = tq;
	assign o_tx_point = tx_pt;
	assign o_sample_strobe = sample_pt;

	// Listen-only loops dominant bits back internally
	assign bus_rx = i_can_rx & ~(ctl_reg.listen_only & i_mac_dominant);
	assign o_tx_start_allowed = running && !ctl_reg.listen_only;

	always_comb begin
		pre_cnt_next = tq ? 6'h00 : pre_cnt_reg + 6'h01;
		seg_next = seg_reg;
		seg_cnt_next = seg_cnt_reg;
		samp_hist_next = samp_hist_reg;
		rx_bit_next = rx_bit_reg;
		tx_next = tx_reg;
		idle_cnt_next = idle_cnt_reg;
		if (!running) begin
			pre_cnt_next = 6'h00;
			seg_next = seg_sync;
			seg_cnt_next = 4'h0;
			tx_next = 1'b1;
		end else if (tq) begin
			seg_cnt_next = seg_cnt_reg + 4'h1;
			samp_hist_next = {samp_hist_reg[1:0], bus_rx};
			unique case (seg_reg)
				seg_sync: begin
					seg_next = seg_one;
					seg_cnt_next = 4'h0;
				end
				seg_one: begin
					if (seg_cnt_reg == seg1_last) begin
						seg_next = seg_two;
						seg_cnt_next = 4'h0;
						// Third sample taken here; two earlier quanta vote with it
						rx_bit_next = timing_reg.three_samp ? majority({samp_hist_reg[1:0], bus_rx})
							: bus_rx;
						idle_cnt_next = (bus_rx && idle_cnt_reg != idle_last) ? idle_cnt_reg + 4'h1
							: (bus_rx ? idle_cnt_reg : 4'h0);
					end
				end
				seg_two: begin
					if (seg_cnt_reg == seg2_last)
						seg_next = seg_sync;
				end
				default: seg_next = seg_sync;
			endcase
			if (tx_pt)
				tx_next = ctl_reg.listen_only ? 1'b1 : i_tx_bit;
		end
		// Pin goes recessive right away, not at the next transmit point
		if (ctl_reg.listen_only)
			tx_next = 1'b1;
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pre_cnt_reg <= 6'h00;
			seg_reg <= seg_sync;
			seg_cnt_reg <= 4'h0;
			samp_hist_reg <= 3'h7;
			rx_bit_reg <= 1'b1;
			tx_reg <= 1'b1;
			idle_cnt_reg <= 4'h0;
		end else begin
			pre_cnt_reg <= pre_cnt_next;
			seg_reg <= seg_next;
			seg_cnt_reg <= seg_cnt_next;
			samp_hist_reg <= samp_hist_next;
			rx_bit_reg <= rx_bit_next;
			tx_reg <= tx_next;
			idle_cnt_reg <= idle_cnt_next;
		end
	end

	assign o_can_tx = tx_reg;
	assign o_rx_bit = rx_bit_reg;

endmodule : can_bit_timing_and_power_modes

/* sim/can_timing_chk.sv */
// Port checker for the CAN bit timing and power mode block
`timescale 1ns/1ps
module can_timing_chk (
	// Clock, reset, inputs
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire can_timing_pkg::cpu_mode_type i_cpu_mode,
	input wire logic i_can_rx,
	// Outputs watched
	input wire logic o_can_tx,
	input wire logic o_tq_tick,
	input wire logic o_sample_strobe,
	input wire logic o_tx_point,
	input wire logic o_tx_start_allowed,
	input wire logic o_engine_clk_en,
	input wire logic o_reg_clk_en,
	input wire logic [2:0] o_jump_width_tq,
	input wire logic o_wakeup_irq
);
	import can_timing_pkg::*;
	// ==========
	// Quanta per bit; first bit after the engine stops is not checked
	logic [4:0] tq_cnt_reg, tq_cnt_next;
	logic seen_reg, seen_next;
	always_comb begin
		tq_cnt_next = o_tx_point ? 5'h00 : tq_cnt_reg + 5'(o_tq_tick);
		seen_next = o_engine_clk_en & (seen_reg | o_tx_point);
	end
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tq_cnt_reg <= 5'h00;
			seen_reg <= 1'b0;
		end else begin
			tq_cnt_reg <= tq_cnt_next;
			seen_reg <= seen_next;
		end
	end
	// ==========
	// Assertions
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);
	a_bit_quanta: assert property (o_tx_point && seen_reg |-> tq_cnt_reg inside {[5'd6:5'd25]})
		else $error("bit length out of range");
	a_listen_recessive: assert property (!$past(o_tx_start_allowed, 2) && !$past(o_tx_start_allowed) &&
		!o_tx_start_allowed |-> o_can_tx)
		else $error("dominant driven while transmit not allowed");
	a_jump_range: assert property (o_jump_width_tq inside {[3'd1:3'd4]})
		else $error("jump width out of range");
	a_irq_sleeping: assert property (o_wakeup_irq |-> !o_engine_clk_en && o_reg_clk_en)
		else $error("wake interrupt outside sleep");
	a_irq_bus: assert property (o_wakeup_irq |-> !i_can_rx)
		else $error("wake interrupt without bus activity");
	a_clock_nest: assert property (o_engine_clk_en |-> o_reg_clk_en)
		else $error("engine clock without register clock");
	a_stop_pdown: assert property ($past(i_cpu_mode, 2) == cpu_stop && $past(i_cpu_mode) == cpu_stop &&
		i_cpu_mode == cpu_stop |-> !o_reg_clk_en)
		else $error("clocks running in stop mode");
	a_strobe_running: assert property (o_sample_strobe || o_tx_point |-> o_engine_clk_en || $past(o_engine_clk_en))
		else $error("bit strobe while clocks stopped");
	a_sample_apart: assert property (o_tx_point |-> !o_sample_strobe ##1 !o_sample_strobe)
		else $error("sample point too close to sync");
	c_wake: cover property (o_wakeup_irq);
	c_stop: cover property (i_cpu_mode == cpu_stop && !o_reg_clk_en);
	c_listen: cover property (o_sample_strobe && !o_tx_start_allowed);
endmodule : can_timing_chk

bind can_bit_timing_and_power_modes can_timing_chk can_timing_chk_inst (.i_ref_clk, .i_arst_n, .i_cpu_mode,
	.i_can_rx, .o_can_tx, .o_tq_tick, .o_sample_strobe, .o_tx_point, .o_tx_start_allowed, .o_engine_clk_en,
	.o_reg_clk_en, .o_jump_width_tq, .o_wakeup_irq);

/* sim/can_bus_node.sv */
// Behavioural model of another node on the shared CAN bus
`timescale 1ns/1ps
module can_bus_node (
	// Clock and command
	input wire logic i_ref_clk,
	input wire logic i_send_dominant,
	// Bus
	input wire logic i_dev_tx,
	output logic o_bus_level
);
	logic drive_reg;
	always_ff @(posedge i_ref_clk) drive_reg <= i_send_dominant;
	// Wired-and: recessive unless some node pulls dominant
	assign o_bus_level = i_dev_tx & ~drive_reg;
endmodule : can_bus_node

/* sim/tb_top.sv */
// Self-checking bench for the CAN bit timing and power mode block
`timescale 1ns/1ps
module tb_top;
	import can_timing_pkg::*;
	// ==========
	// Signals
	logic clk, rst_n, psel, pen, pwr, rx_busy, tx_bit, mac_dom, node_dom;
	logic pready, pslverr, can_rx, can_tx, tq_tick, samp, txp, rx_bit, tx_ok, eng_en, reg_en, wirq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, v;
	logic [2:0] sjw_tq, tx_empty;
	logic [31:0] seed = 32'h4e;
	cpu_mode_type cpu_mode;
	int err_total = 0, total_checks = 0, cyc = 0, p, s1, s2, j, t0;
	localparam logic [31:0] en_b = 32'h1 << module_enable_pos;
	can_bit_timing_and_power_modes can_bit_timing_and_power_modes_inst (.i_ref_clk(clk), .i_arst_n(rst_n),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
		.o_prdata(prdata), .o_pslverr(pslverr), .i_cpu_mode(cpu_mode), .i_tx_buffer_empty_flag(tx_empty),
		.i_rx_busy(rx_busy), .i_tx_bit(tx_bit), .i_mac_dominant(mac_dom), .i_can_rx(can_rx), .o_can_tx(can_tx),
		.o_tq_tick(tq_tick), .o_sample_strobe(samp), .o_tx_point(txp), .o_rx_bit(rx_bit),
		.o_tx_start_allowed(tx_ok), .o_engine_clk_en(eng_en), .o_reg_clk_en(reg_en),
		.o_jump_width_tq(sjw_tq), .o_wakeup_irq(wirq));
	can_bus_node can_bus_node_inst (.i_ref_clk(clk), .i_send_dominant(node_dom), .i_dev_tx(can_tx),
		.o_bus_level(can_rx));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	// ==========
	// Helpers
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function int bit_clks(input int pv, input int a, input int b);
		return (pv + 1) * (sync_seg_tq + a + 1 + b + 1);
	endfunction : bit_clks
	task conclude();
		if (err_total == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task chk1(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chk1
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_total++;
			conclude();
		end
		q = prdata;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : xfer
	task wpt(input bit smp);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((smp ? samp : txp) !== 1'b1 && n < 400);
		if (n >= 400) begin
			err_total++;
			conclude();
		end
	endtask : wpt
	// ==========
	// Main sequence
	initial begin
		{rst_n, psel, pen, pwr, rx_busy, mac_dom, node_dom, paddr, pwdata} = '0;
		tx_bit = 1'b1;
		tx_empty = 3'h7;
		cpu_mode = cpu_run;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			rst_n <= 1'b0;
			repeat (4) @(posedge clk);
			rst_n <= 1'b1;
			@(posedge clk);
			if (k == 0) begin
				xfer(1'b0, bit_timing_reg_a_off, 32'h0);
				chk(q, {24'h0, btr_a_rst});
				xfer(1'b0, bit_timing_reg_b_off, 32'h0);
				chk(q, {24'h0, btr_b_rst});
				xfer(1'b0, status_reg_off, 32'h0);
				chk(q & 32'hf, 32'h1 << disabled_pos);
				chk1(reg_en, 1'b0);
				chk1(pslverr, 1'b0);
				xfer(1'b1, 12'h010, 32'hff);
				xfer(1'b0, 12'h010, 32'h0);
				chk(q, 32'h0);
			end
			p = (k == 1) ? 0 : xs() % 4;
			s1 = (k == 0) ? 15 : (k == 1) ? 3 : 3 + xs() % 13;
			s2 = (k == 0) ? 7 : (k == 1) ? 1 : 1 + xs() % 7;
			j = (k == 0) ? 3 : xs() % ((s2 < 3 ? s2 : 3) + 1);
			xfer(1'b1, bit_timing_reg_a_off, 32'((j << jump_width_lsb) | p));
			v = 32'(((xs() % 2) << three_samp_bit) | (s2 << seg2_lsb) | s1);
			xfer(1'b1, bit_timing_reg_b_off, v);
			xfer(1'b0, bit_timing_reg_b_off, 32'h0);
			chk(q, v);
			chk(32'(sjw_tq), 32'(j + 1));
			xfer(1'b1, control_reg_a_off, en_b);
			xfer(1'b0, status_reg_off, 32'h0);
			chk(q & 32'h7, 32'h0);
			xfer(1'b1, bit_timing_reg_b_off, ~v & 32'hff);
			xfer(1'b0, bit_timing_reg_b_off, 32'h0);
			chk(q, v);
			wpt(1'b0);
			t0 = cyc;
			wpt(1'b0);
			chk(32'(cyc - t0), 32'(bit_clks(p, s1, s2)));
		end
		@(posedge clk);
		tx_bit <= 1'b0;
		wpt(1'b0);
		wpt(1'b1);
		chk1(can_tx, 1'b0);
		wpt(1'b0);
		chk1(rx_bit, 1'b0);
		@(posedge clk);
		tx_bit <= 1'b1;
		node_dom <= 1'b1;
		wpt(1'b0);
		wpt(1'b1);
		chk1(can_tx, 1'b1);
		wpt(1'b0);
		chk1(rx_bit, 1'b0);
		@(posedge clk);
		node_dom <= 1'b0;
		xfer(1'b1, control_reg_a_off, en_b | (32'h1 << listen_only_pos));
		tx_bit <= 1'b0;
		mac_dom <= 1'b1;
		wpt(1'b0);
		wpt(1'b0);
		chk1(tx_ok, 1'b0);
		chk1(can_tx, 1'b1);
		wpt(1'b1);
		wpt(1'b0);
		chk1(rx_bit, 1'b0);
		@(posedge clk);
		mac_dom <= 1'b0;
		tx_bit <= 1'b1;
		tx_empty <= 3'h6;
		rx_busy <= 1'b1;
		v = en_b | (32'h1 << sleep_req_pos) | (32'h1 << wakeup_en_pos) | (32'h1 << wakeup_irq_en_pos);
		xfer(1'b1, control_reg_a_off, v);
		repeat (60) @(posedge clk);
		xfer(1'b0, status_reg_off, 32'h0);
		chk(q & 32'h1, 32'h0);
		tx_empty <= 3'h7;
		repeat (60) @(posedge clk);
		xfer(1'b0, status_reg_off, 32'h0);
		chk(q & 32'h1, 32'h0);
		rx_busy <= 1'b0;
		t0 = 0;
		do begin
			xfer(1'b0, status_reg_off, 32'h0);
			t0++;
		end while (q[sleep_ack_pos] !== 1'b1 && t0 < 800);
		chk(q & 32'hf, 32'h1 << sleep_ack_pos);
		xfer(1'b0, control_reg_a_off, 32'h0);
		chk(q, v);
		chk1(eng_en, 1'b0);
		chk1(reg_en, 1'b1);
		node_dom <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		chk1(wirq, 1'b1);
		@(posedge clk);
		node_dom <= 1'b0;
		repeat (3) @(posedge clk);
		chk1(eng_en, 1'b1);
		for (int m = 0; m < 4; m++) begin
			xfer(1'b1, control_reg_a_off, en_b | (m % 2 == 0 ? 32'h1 << stop_in_wait_pos : 32'h0));
			cpu_mode <= (m == 3) ? cpu_stop : (m == 0) ? cpu_run : cpu_wait;
			repeat (2) @(posedge clk);
			@(negedge clk);
			chk1(reg_en, 1'(m < 2));
			@(posedge clk);
			cpu_mode <= cpu_run;
			repeat (2) @(posedge clk);
			@(negedge clk);
			chk1(eng_en, 1'b1);
			@(posedge clk);
		end
		conclude();
	end
endmodule : tb_top
